// file: hw/bit_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser for a group of asynchronous levels
module bit_sync #(
    parameter WIDTH = 3
) (
    // Clock and reset
    input wire core_clk,
    input wire reset,
    // Levels
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_reg;

    always @(posedge core_clk) begin
        if (reset) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// file: hw/serial_port_defs.vh
`ifndef SERIAL_PORT_DEFS_VH
`define SERIAL_PORT_DEFS_VH

// Instruction word
`define INSTR_BITS 16
`define ADDR_BITS 14
`define INSTR_RW_BIT 15
// Port configuration register at address zero
`define CFG_ADDR 14'h0000
`define CFG_LSB_FIRST_BIT 6
`define CFG_ASCEND_BIT 5
`define CFG_RESET_VALUE 8'h00
// Size of the fixed common layout at the bottom of the map
`define COMMON_REGION_SIZE 16
// Address range of the map
`define ADDR_TOP 14'h3A3B
`define ADDR_BOTTOM 14'h0000
// Port choice encodings
`define PORT_IS_SPI 1'b0
`define PORT_IS_I2C 1'b1

`endif

// file: hw/unified_serial_control_port.v
`timescale 1ns/1ps
// Overview of operation
// - No byte count; payload length set only by how long select stays low.
// - Select going high ends transfer, drops partial byte, awaits new instruction.
// - Old length bit positions decode as address bits A13 and A12.
// - Address step direction follows only the ascend bit, not bit order.
// - Lowest 16 addresses follow the fixed common port layout.
// - Port configuration lives in register address zero.
// - Host may both read and write the register map.
// - Exactly one of SPI or I2C enabled, chosen by the strap at start-up.
// - Selected protocol stays fixed until reset; nothing else changes it.
// - 16-bit instruction: read flag in MSB, 15-bit address, top bit ignored.
// - Write bits sampled on rising clock; read bits launched on falling edge.
// - Ascend bit 0 decrements toward 0x0000, 1 increments toward 0x3A3B.
// - Bit D6 set makes next transfers LSB first; default MSB first.
`include "serial_port_defs.vh"

module unified_serial_control_port #(
    parameter ADDR_W = `ADDR_BITS
) (
    // Clock and reset
    input wire core_clk,
    input wire reset,
    // Serial pins
    input wire select_low,
    input wire sclk,
    input wire sdio_in,
    output reg sdio_out,
    output reg sdio_oe,
    // Start-up strap
    input wire port_choice_strap_pin,
    output reg spi_enabled,
    output reg i2c_enabled,
    // Register map access
    output reg [ADDR_W-1:0] map_addr,
    output reg [7:0] map_wdata,
    output reg map_wr,
    output reg map_rd,
    input wire [7:0] map_rdata,
    // Port configuration visible to the core
    output reg lsb_first,
    output reg addr_ascend
);
    localparam ST_INSTR = 3'b001;
    localparam ST_WRITE = 3'b010;
    localparam ST_READ = 3'b100;

    wire [2:0] pins_sync;
    wire sel_s;
    wire sclk_s;
    wire din_s;
    reg sclk_d_reg;
    reg [2:0] state_reg;
    reg [15:0] shift_reg;
    reg [4:0] count_reg;
    reg [7:0] out_reg;
    reg strap_taken_reg;
    reg [ADDR_W-1:0] addr_reg;
    reg lsb_now_reg;
    reg strap_meta_reg;
    reg strap_sync_reg;
    localparam [7:0] CFG_RST = `CFG_RESET_VALUE;

    // Select is carried inverted so the synchroniser's reset level reads as deselected
    bit_sync #(
        .WIDTH(3)
    ) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .async_in({~select_low, sclk, sdio_in}),
        .sync_out(pins_sync)
    );

    assign sel_s = ~pins_sync[2];
    assign sclk_s = pins_sync[1];
    assign din_s = pins_sync[0];

    // Link ignored while deselected or when the strap chose the other protocol
    wire active = ~sel_s & spi_enabled;
    wire rise = active & sclk_s & ~sclk_d_reg;
    wire fall = active & ~sclk_s & sclk_d_reg;

    // Next address in a stream, held inside the map range
    function [ADDR_W-1:0] step_addr;
        input [ADDR_W-1:0] a;
        input up;
        begin
            if (up)
                step_addr = (a == `ADDR_TOP) ? a : a + 1'b1;
            else
                step_addr = (a == `ADDR_BOTTOM) ? a : a - 1'b1;
        end
    endfunction

    // Reorder a byte according to the transfer bit order
    function [7:0] order_byte;
        input [7:0] b;
        input lsb;
        integer i;
        begin
            order_byte = b;
            if (lsb) begin
                for (i = 0; i < 8; i = i + 1)
                    order_byte[i] = b[7-i];
            end
        end
    endfunction

    // LSB-first instruction: A0 arrived first, A14 sits in shift_reg[0] and is dropped
    wire [ADDR_W-1:0] lsb_addr = {shift_reg[1], shift_reg[2], shift_reg[3], shift_reg[4], shift_reg[5],
        shift_reg[6], shift_reg[7], shift_reg[8], shift_reg[9], shift_reg[10], shift_reg[11], shift_reg[12],
        shift_reg[13], shift_reg[14]};
    wire [7:0] wr_byte = order_byte({shift_reg[6:0], din_s}, lsb_now_reg);
    wire [7:0] rd_byte = order_byte(map_rdata, lsb_now_reg);

    // Strap flops run through reset, so a settled level is ready at release
    always @(posedge core_clk) begin
        strap_meta_reg <= port_choice_strap_pin;
        strap_sync_reg <= strap_meta_reg;
    end

    // Strap is caught once after reset release and then frozen
    always @(posedge core_clk) begin
        if (reset) begin
            strap_taken_reg <= 1'b0;
            spi_enabled <= 1'b0;
            i2c_enabled <= 1'b0;
        end else if (!strap_taken_reg) begin
            strap_taken_reg <= 1'b1;
            spi_enabled <= (strap_sync_reg == `PORT_IS_SPI);
            i2c_enabled <= (strap_sync_reg == `PORT_IS_I2C);
        end
        // No other path writes the port choice
    end

    always @(posedge core_clk) begin
        if (reset) begin
            sclk_d_reg <= 1'b0;
            state_reg <= ST_INSTR;
            shift_reg <= 16'h0000;
            count_reg <= 5'h00;
            out_reg <= 8'h00;
            addr_reg <= {ADDR_W{1'b0}};
            lsb_now_reg <= 1'b0;
            sdio_out <= 1'b0;
            sdio_oe <= 1'b0;
            map_addr <= {ADDR_W{1'b0}};
            map_wdata <= 8'h00;
            map_wr <= 1'b0;
            map_rd <= 1'b0;
            lsb_first <= CFG_RST[`CFG_LSB_FIRST_BIT];
            addr_ascend <= CFG_RST[`CFG_ASCEND_BIT];
        end else begin
            sclk_d_reg <= sclk_s;
            map_wr <= 1'b0;
            map_rd <= 1'b0;
            if (!active) begin
                // Select high: drop partial byte, await instruction
                state_reg <= ST_INSTR;
                count_reg <= 5'h00;
                sdio_oe <= 1'b0;
                lsb_now_reg <= lsb_first;
            end else if (rise) begin
                shift_reg <= {shift_reg[14:0], din_s};
                count_reg <= count_reg + 5'h01;
                case (state_reg)
                    ST_INSTR: begin
                        if (count_reg == `INSTR_BITS - 1) begin
                            count_reg <= 5'h00;
                            // A14 dropped, A13/A12 taken as address bits
                            if (lsb_now_reg) begin
                                // Read flag is the last bit of a reversed word
                                addr_reg <= lsb_addr;
                                map_addr <= lsb_addr;
                                state_reg <= din_s ? ST_READ : ST_WRITE;
                                map_rd <= din_s;
                            end else begin
                                addr_reg <= {shift_reg[12:0], din_s};
                                map_addr <= {shift_reg[12:0], din_s};
                                state_reg <= shift_reg[14] ? ST_READ : ST_WRITE;
                                map_rd <= shift_reg[14];
                            end
                        end
                    end
                    ST_WRITE: begin
                        if (count_reg[2:0] == 3'h7) begin
                            count_reg <= 5'h00;
                            map_addr <= addr_reg;
                            map_wdata <= wr_byte;
                            map_wr <= 1'b1;
                            if (addr_reg == `CFG_ADDR) begin
                                lsb_first <= wr_byte[`CFG_LSB_FIRST_BIT];
                                addr_ascend <= wr_byte[`CFG_ASCEND_BIT];
                            end
                            addr_reg <= step_addr(addr_reg, addr_ascend);
                        end
                    end
                    ST_READ: begin
                        if (count_reg[2:0] == 3'h7) begin
                            count_reg <= 5'h00;
                            map_addr <= addr_reg;
                            map_rd <= 1'b1;
                        end
                    end
                    default: state_reg <= ST_INSTR;
                endcase
            end else if (fall && state_reg == ST_READ) begin
                sdio_oe <= 1'b1;
                if (count_reg[2:0] == 3'h0) begin
                    // Start of a byte: take fresh map data, then advance
                    // Map data was requested at least one cycle ago, so it is settled here
                    out_reg <= {rd_byte[6:0], 1'b0};
                    sdio_out <= rd_byte[7];
                    addr_reg <= step_addr(addr_reg, addr_ascend);
                end else begin
                    sdio_out <= out_reg[7];
                    out_reg <= out_reg << 1;
                end
            end
        end
    end
endmodule

// file: verif/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
    // Clock
    input wire core_clk,
    // Serial pins
    input wire sdio_out,
    output reg select_low,
    output reg sclk,
    output reg sdio_in
);
    reg [7:0] wbuf [0:3];
    reg [7:0] rbuf [0:3];
    initial begin
        select_low = 1'b1;
        sclk = 1'b0;
        sdio_in = 1'b0;
    end
    task half;
        repeat (4) @(negedge core_clk);
    endtask
    // Instruction then open-ended payload; nbits need not fill whole bytes
    task frame(input rw, input [14:0] a, input integer nbits, input lsb);
        reg [15:0] w;
        integer b;
        begin
            w = {rw, a};
            select_low = 1'b0;
            half;
            for (b = 0; b < 16 + nbits; b = b + 1) begin
                if (b < 16) sdio_in = lsb ? w[b] : w[15-b];
                else if (!rw) sdio_in = wbuf[(b-16)/8][lsb ? b%8 : 7-b%8];
                half;
                sclk = 1'b1;
                if (rw && b >= 16) rbuf[(b-16)/8][lsb ? b%8 : 7-b%8] = sdio_out;
                half;
                sclk = 1'b0;
            end
            select_low = 1'b1;
            // Released line toggles so a stale bit is never read as live
            sdio_in = ~sdio_in;
            repeat (3) half;
        end
    endtask
endmodule

// file: verif/tb_unified_serial_control_port.sv
`timescale 1ns/1ps
module tb_unified_serial_control_port;
    reg core_clk = 1'b0;
    reg reset = 1'b1;
    reg port_choice_strap_pin = 1'b0;
    wire select_low, sclk, sdio_in, sdio_out, sdio_oe, spi_enabled, i2c_enabled, map_wr, map_rd;
    wire lsb_first, addr_ascend;
    wire [13:0] map_addr;
    wire [7:0] map_wdata;
    // Map data is a fixed function of address so reads are predictable
    wire [7:0] map_rdata = map_addr[7:0] ^ 8'h5A;
    integer miscompares = 0;
    integer num_checks = 0;
    integer cycles = 0;
    integer rd_pulses = 0;
    reg oe_seen = 1'b0;
    reg [13:0] wa [$];
    reg [7:0] wd [$];
    always #20 core_clk = ~core_clk;
    unified_serial_control_port DUT (.core_clk, .reset, .select_low, .sclk, .sdio_in, .sdio_out, .sdio_oe,
        .port_choice_strap_pin, .spi_enabled, .i2c_enabled, .map_addr, .map_wdata, .map_wr, .map_rd, .map_rdata,
        .lsb_first, .addr_ascend);
    spi_host_model host (.core_clk, .sdio_out, .select_low, .sclk, .sdio_in);
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Outputs are sampled mid-cycle, away from the edge that launches them
    always @(negedge core_clk) begin
        cycles = cycles + 1;
        if (map_rd === 1'b1) rd_pulses = rd_pulses + 1;
        if (sdio_oe === 1'b1) oe_seen = 1'b1;
        if (map_wr === 1'b1) begin
            wa.push_back(map_addr);
            wd.push_back(map_wdata);
        end
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            final_report;
        end
    end
    task check(input ok);
        num_checks = num_checks + 1;
        if (ok !== 1'b1) begin
            miscompares = miscompares + 1;
            $display("[FAIL] %0t check %0d mismatch", $time, num_checks);
        end
    endtask
    task do_reset(input s);
        reset = 1'b1;
        port_choice_strap_pin = s;
        repeat (5) @(negedge core_clk);
        reset = 1'b0;
        repeat (4) @(negedge core_clk);
    endtask
    task wr1(input [14:0] a, input [7:0] d, input lsb);
        host.wbuf[0] = d;
        host.frame(1'b0, a, 8, lsb);
    endtask
    task t_stream;
        wa.delete();
        wd.delete();
        host.wbuf[0] = 8'hC3;
        host.wbuf[1] = 8'h3C;
        host.wbuf[2] = 8'hFF;
        host.frame(1'b0, 15'h7A3A, 21, 1'b0);
        check(wa.size() == 2);
        check(wa[0] === 14'h3A3A && wd[0] === 8'hC3);
        check(wa[1] === 14'h3A39 && wd[1] === 8'h3C);
        $display("stream test done");
    endtask
    task t_cfg;
        wr1(15'h0000, 8'h20, 1'b0);
        check(addr_ascend === 1'b1 && lsb_first === 1'b0);
        wa.delete();
        wd.delete();
        host.wbuf[0] = 8'h11;
        host.wbuf[1] = 8'h22;
        host.wbuf[2] = 8'h33;
        host.frame(1'b0, 15'h3A3A, 24, 1'b0);
        check(wa[1] === 14'h3A3B && wa[2] === 14'h3A3B);
        check(wd[0] === 8'h11 && wd[2] === 8'h33);
        wr1(15'h0000, 8'h60, 1'b0);
        check(lsb_first === 1'b1);
        rd_pulses = 0;
        oe_seen = 1'b0;
        host.frame(1'b1, 15'h1234, 16, 1'b1);
        check(host.rbuf[0] === 8'h6E && host.rbuf[1] === 8'h6F);
        check(rd_pulses == 3 && oe_seen === 1'b1);
        wr1(15'h0000, 8'h00, 1'b1);
        check(lsb_first === 1'b0 && addr_ascend === 1'b0);
        host.frame(1'b1, 15'h0011, 16, 1'b0);
        check(host.rbuf[0] === 8'h4B && host.rbuf[1] === 8'h4A);
        $display("config test done");
    endtask
    task t_strap;
        do_reset(1'b1);
        check(i2c_enabled === 1'b1 && spi_enabled === 1'b0);
        wa.delete();
        wr1(15'h0100, 8'hFF, 1'b0);
        port_choice_strap_pin = 1'b0;
        repeat (4) @(negedge core_clk);
        check(wa.size() == 0 && i2c_enabled === 1'b1);
        do_reset(1'b0);
        check(spi_enabled === 1'b1 && i2c_enabled === 1'b0);
        $display("strap test done");
    endtask
    initial begin
        do_reset(1'b0);
        t_stream;
        t_cfg;
        t_strap;
        final_report;
    end
endmodule
bind unified_serial_control_port usc_chk #(.ADDR_W(ADDR_W)) u_chk (.core_clk, .reset, .select_low, .sdio_oe,
    .port_choice_strap_pin, .spi_enabled, .i2c_enabled, .map_addr, .map_wr, .map_rd, .lsb_first, .addr_ascend);

// file: verif/usc_port_props.sv
`timescale 1ns/1ps
module usc_chk #(
    parameter ADDR_W = 14
) (
    // Clock and reset
    input wire core_clk,
    input wire reset,
    // Pins and strap
    input wire select_low,
    input wire sdio_oe,
    input wire port_choice_strap_pin,
    input wire spi_enabled,
    input wire i2c_enabled,
    // Map side
    input wire [ADDR_W-1:0] map_addr,
    input wire map_wr,
    input wire map_rd,
    input wire lsb_first,
    input wire addr_ascend
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    reg [3:0] hi_reg;
    reg seen_reg;
    reg [ADDR_W-1:0] last_reg;
    // Forget the last write only once select has long settled high
    always @(posedge core_clk) begin
        hi_reg <= (reset || !select_low) ? 4'h0 : hi_reg + {3'h0, hi_reg != 4'hF};
        seen_reg <= (reset || hi_reg == 4'h8) ? 1'b0 : seen_reg | map_wr;
        last_reg <= map_wr ? map_addr : last_reg;
    end
    wire [ADDR_W-1:0] up_a = (last_reg == 14'h3A3B) ? last_reg : last_reg + 1'b1;
    wire [ADDR_W-1:0] dn_a = (last_reg == 14'h0000) ? last_reg : last_reg - 1'b1;
    sequence s_settled; !$past(reset) && !$past(reset, 2); endsequence
    sequence s_idle; select_low [*8]; endsequence
    property p_one; s_settled |-> spi_enabled != i2c_enabled; endproperty
    property p_fixed; s_settled |-> $stable(spi_enabled) && $stable(i2c_enabled); endproperty
    property p_strap; $fell(reset) |=> i2c_enabled == $past(port_choice_strap_pin); endproperty
    property p_idle; s_idle |-> !map_wr && !map_rd && !sdio_oe; endproperty
    property p_i2c; i2c_enabled |-> !map_wr && !map_rd && !sdio_oe; endproperty
    property p_gap; map_wr |=> !map_wr [*8]; endproperty
    property p_step; map_wr && seen_reg |-> map_addr == (addr_ascend ? up_a : dn_a); endproperty
    property p_cfg;
        $changed({lsb_first, addr_ascend}) && !$past(reset) |->
            map_wr && map_addr == 0 || $past(map_wr) && $past(map_addr) == 0;
    endproperty
    a_one: assert property (p_one) else $error("enables not exclusive");
    a_fixed: assert property (p_fixed) else $error("protocol changed");
    a_strap: assert property (p_strap) else $error("strap not taken");
    a_idle: assert property (p_idle) else $error("activity while deselected");
    a_i2c: assert property (p_i2c) else $error("spi activity in i2c mode");
    a_gap: assert property (p_gap) else $error("byte writes too close");
    a_step: assert property (p_step) else $error("bad address step");
    a_cfg: assert property (p_cfg) else $error("config changed without write");
endmodule
